// ==== common/vcc_pkg.sv ====
// Package for the voltage comparator control block: register map, field positions, reset values.
// Assumes a 32-bit APB slave with byte addresses; registers are 8 bits wide in the low lanes.
package vcc_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_ANALOG_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_SELECT_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // Field positions
  localparam int CMP_EN_BIT = 7;
  localparam int RESULT_BIT = 7;
  localparam int PAD_OE_BIT = 6;
  localparam int IRQ_EN_BIT = 0;
  localparam int GIE_BIT = 1;
  localparam int FLAG_BIT = 0;
  localparam int CTRL_FLAG_BIT = 2;
  localparam int LEVEL_LSB = 0;
  localparam int PAIR_LSB = 4;

  // Field codes
  localparam logic [3:0] LEVEL_PAD_TO_PAD = 4'h0;
  localparam logic [3:0] PAIR_0 = 4'h0;
  localparam logic [3:0] PAIR_1 = 4'h1;
  localparam logic [3:0] PAIR_2 = 4'h2;
  localparam logic [3:0] PAIR_3 = 4'h3;
  localparam logic [3:0] PAD_NONE = 4'h0;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_TAP = 16'h0000;

  // Mode enumeration, one-hot
  typedef enum logic [2:0] {
    VCC_MODE_OFF = 3'b001,
    VCC_MODE_P2P = 3'b010,
    VCC_MODE_P2R = 3'b100
  } vcc_mode_e;

endpackage : vcc_pkg

// ==== hdl/vcc_top.sv ====
// Voltage comparator digital control: enable/halt gating, mode decode, analog selects,
// result synchroniser, change flag with interrupt, pad output override. APB register access.
// Assumes one clock pclk at 40 MHz; the comparator output is asynchronous analog-side logic.
//
// What this block does
// - The comparator is off after reset and runs only while the enable bit (bit 7 of the analog enable register) is one.
// - Halt mode forces the comparator off whatever the enable bit says.
// - Level field zero selects pad-to-pad mode, values one to fifteen select pad-to-reference mode.
// - In pad-to-reference mode a level value n selects ladder tap n/16 for the inverting input.
// - In pad-to-reference mode pair codes 0 to 3 route pins a0 to a3 to the non-inverting input, others none.
// - In pad-to-pad mode codes 0 to 3 route a0/a1, a1/a0, a2/a3, a3/a2 to the two inputs, others none.
// - The reference ladder goes only to the inverting input, never the non-inverting one.
// - The change flag is set whenever the comparator is active and the live result differs from its registered copy.
// - Reading the status register loads the live result into the registered copy; software then clears the flag.
// - An interrupt request is raised when the flag is set with both comparator enable and irq enable one.
// - The result reads as bit 7 of the status register.
// - With the pad output enable (status bit 6) one, pin b3 carries the live result.
// - While the pad output enable is one the pulse-width output on that pin is disabled.
// - The request reaches the processor only while the global interrupt enable is one.
`timescale 1ns/1ps

module vcc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_mode,
  input wire logic comparator_raw,
  input wire logic pulse_width_output_one_in,
  input wire logic pulse_width_output_one_en,
  output logic comparator_power_on,
  output logic [15:0] ladder_tap_sel,
  output logic [3:0] noninv_pad_sel,
  output logic [3:0] inv_pad_sel,
  output logic port_b_pin_3_out,
  output logic port_b_pin_3_oe,
  output logic compare_irq,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode helpers

  logic [7:0] analog_enable_reg_r;
  logic [7:0] comparator_select_control_r;
  logic compare_pad_output_enable_r;
  logic compare_irq_enable_r;
  logic global_irq_enable_r;
  logic compare_irq_flag_r;
  logic irq_mask_r;
  logic sync1_r;
  logic sync2_r;
  logic copy_r;
  vcc_pkg::vcc_mode_e mode;
  logic comparator_enable;
  logic cmp_active;
  logic [3:0] reference_level_select;
  logic [3:0] pad_pair_select;
  logic wr;
  logic rd;
  logic mapped;
  logic change;
  logic [7:0] rbyte;

  // One-hot pad select from a two-bit pad index
  function automatic logic [3:0] pad_onehot(input logic [1:0] idx);
    pad_onehot = 4'h1 << idx;
  endfunction : pad_onehot

  // Address decode is used for both the write enable and the error answer
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == vcc_pkg::ADDR_ANALOG_ENABLE) || (a == vcc_pkg::ADDR_SELECT_CTRL) ||
                  (a == vcc_pkg::ADDR_STATUS) || (a == vcc_pkg::ADDR_IRQ_CTRL) ||
                  (a == vcc_pkg::ADDR_IRQ_FLAG) || (a == vcc_pkg::ADDR_IRQ_MASK);
  endfunction : addr_mapped

  // Bus strobes: the access phase completes in one cycle since pready is registered high after every setup phase
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign mapped = addr_mapped(paddr);
  assign comparator_enable = analog_enable_reg_r[vcc_pkg::CMP_EN_BIT];
  assign cmp_active = comparator_enable && !halt_mode;
  assign reference_level_select = comparator_select_control_r[vcc_pkg::LEVEL_LSB +: 4];
  assign pad_pair_select = comparator_select_control_r[vcc_pkg::PAIR_LSB +: 4];
  // Mismatch of synchronised result against the copy software last read
  assign change = cmp_active && (sync2_r != copy_r);

  // Mode decode
  always_comb begin
    if (!cmp_active) begin
      mode = vcc_pkg::VCC_MODE_OFF;
    end else if (reference_level_select == vcc_pkg::LEVEL_PAD_TO_PAD) begin
      mode = vcc_pkg::VCC_MODE_P2P;
    end else begin
      mode = vcc_pkg::VCC_MODE_P2R;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  // Control registers; all reset to zero so the comparator starts off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_enable_reg_r <= vcc_pkg::RST_BYTE;
      comparator_select_control_r <= vcc_pkg::RST_BYTE;
      compare_pad_output_enable_r <= 1'b0;
      compare_irq_enable_r <= 1'b0;
      global_irq_enable_r <= 1'b0;
      irq_mask_r <= 1'b0;
    end else if (wr && mapped) begin
      case (paddr)
        vcc_pkg::ADDR_ANALOG_ENABLE: analog_enable_reg_r <= pwdata[7:0];
        vcc_pkg::ADDR_SELECT_CTRL: comparator_select_control_r <= pwdata[7:0];
        vcc_pkg::ADDR_STATUS: compare_pad_output_enable_r <= pwdata[vcc_pkg::PAD_OE_BIT];
        vcc_pkg::ADDR_IRQ_CTRL: begin
          compare_irq_enable_r <= pwdata[vcc_pkg::IRQ_EN_BIT];
          global_irq_enable_r <= pwdata[vcc_pkg::GIE_BIT];
        end
        vcc_pkg::ADDR_IRQ_MASK: irq_mask_r <= pwdata[vcc_pkg::FLAG_BIT];
        default: ;
      endcase
    end
  end

  // Two-stage synchroniser; only the second stage is looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= comparator_raw;
      sync2_r <= sync1_r;
    end
  end

  // Registered copy is reloaded only by a status read, so a missed read keeps the flag armed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      copy_r <= 1'b0;
    end else if (rd && paddr == vcc_pkg::ADDR_STATUS) begin
      copy_r <= sync2_r;
    end
  end

  // Sticky change flag: cleared by writing zero (or writing one to the W1C alias); set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_irq_flag_r <= 1'b0;
    end else if (change) begin
      compare_irq_flag_r <= 1'b1;
    end else if (wr && paddr == vcc_pkg::ADDR_IRQ_CTRL && !pwdata[vcc_pkg::CTRL_FLAG_BIT]) begin
      compare_irq_flag_r <= 1'b0;
    end else if (wr && paddr == vcc_pkg::ADDR_IRQ_FLAG && pwdata[vcc_pkg::FLAG_BIT]) begin
      compare_irq_flag_r <= 1'b0;
    end
  end

  // Read data byte
  always_comb begin
    case (paddr)
      vcc_pkg::ADDR_ANALOG_ENABLE: rbyte = analog_enable_reg_r;
      vcc_pkg::ADDR_SELECT_CTRL: rbyte = comparator_select_control_r;
      vcc_pkg::ADDR_STATUS: rbyte = {sync2_r, compare_pad_output_enable_r, 6'h00};
      vcc_pkg::ADDR_IRQ_CTRL: rbyte = {5'h00, compare_irq_flag_r, global_irq_enable_r, compare_irq_enable_r};
      vcc_pkg::ADDR_IRQ_FLAG: rbyte = {7'h00, compare_irq_flag_r};
      vcc_pkg::ADDR_IRQ_MASK: rbyte = {7'h00, irq_mask_r};
      default: rbyte = vcc_pkg::RST_BYTE;
    endcase
  end

  // APB answer: zero wait states, error on an unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= {24'h000000, rbyte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog selects and pad routing

  // Ladder only ever feeds the inverting side; the non-inverting side sees pads only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_power_on <= 1'b0;
      ladder_tap_sel <= vcc_pkg::RST_TAP;
      noninv_pad_sel <= vcc_pkg::PAD_NONE;
      inv_pad_sel <= vcc_pkg::PAD_NONE;
    end else begin
      comparator_power_on <= cmp_active;
      ladder_tap_sel <= vcc_pkg::RST_TAP;
      noninv_pad_sel <= vcc_pkg::PAD_NONE;
      inv_pad_sel <= vcc_pkg::PAD_NONE;
      case (mode)
        vcc_pkg::VCC_MODE_P2R: begin
          ladder_tap_sel <= 16'h0001 << reference_level_select;
          if (pad_pair_select[3:2] == 2'b00) begin
            noninv_pad_sel <= pad_onehot(pad_pair_select[1:0]);
          end
        end
        vcc_pkg::VCC_MODE_P2P: begin
          if (pad_pair_select[3:2] == 2'b00) begin
            noninv_pad_sel <= pad_onehot(pad_pair_select[1:0]);
            inv_pad_sel <= pad_onehot(pad_pair_select[1:0] ^ 2'b01);
          end
        end
        vcc_pkg::VCC_MODE_OFF: ;
        default: ;
      endcase
    end
  end

  // Pin b3: live result overrides the pulse-width output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_pin_3_out <= 1'b0;
      port_b_pin_3_oe <= 1'b0;
    end else if (compare_pad_output_enable_r) begin
      port_b_pin_3_out <= sync2_r;
      port_b_pin_3_oe <= 1'b1;
    end else begin
      port_b_pin_3_out <= pulse_width_output_one_in;
      port_b_pin_3_oe <= pulse_width_output_one_en;
    end
  end

  // Interrupt outputs: processor request gated by global enable, plus a masked level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      compare_irq <= compare_irq_flag_r && comparator_enable && compare_irq_enable_r
                     && global_irq_enable_r;
      irq <= compare_irq_flag_r && irq_mask_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_RESET_OFF: assert property (@(posedge pclk) $rose(presetn) |-> !comparator_power_on)
    else $error("comparator on right after reset");
  AST_HALT: assert property (@(posedge pclk) disable iff (!presetn) halt_mode |=> !comparator_power_on)
    else $error("comparator on during halt");
  AST_P2P_NO_LADDER: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == vcc_pkg::VCC_MODE_P2P) |=> ladder_tap_sel == 16'h0000)
    else $error("ladder used in pad mode");
  AST_TAP: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == vcc_pkg::VCC_MODE_P2R) |=> ladder_tap_sel == (16'h0001 << $past(reference_level_select)))
    else $error("wrong ladder tap");
  AST_NO_INV_PAD_P2R: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == vcc_pkg::VCC_MODE_P2R) |=> inv_pad_sel == 4'h0)
    else $error("pad on inverting input with ladder");
  AST_P2P_SWAP: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == vcc_pkg::VCC_MODE_P2P && pad_pair_select == vcc_pkg::PAIR_1) |=>
    noninv_pad_sel == 4'h2 && inv_pad_sel == 4'h1)
    else $error("swap pair wrong");
  AST_P2R_NONE: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == vcc_pkg::VCC_MODE_P2R && pad_pair_select[3:2] != 2'b00) |=> noninv_pad_sel == 4'h0)
    else $error("pad chosen for reserved code");
  AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn) change |=> compare_irq_flag_r)
    else $error("flag missed change");
  AST_FLAG_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    compare_irq_flag_r && !wr |=> compare_irq_flag_r)
    else $error("flag cleared by hardware");
  AST_COPY: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == vcc_pkg::ADDR_STATUS |=> copy_r == $past(sync2_r))
    else $error("copy not loaded");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    compare_irq |-> $past(compare_irq_flag_r && comparator_enable && compare_irq_enable_r && global_irq_enable_r))
    else $error("spurious request");
  AST_PAD: assert property (@(posedge pclk) disable iff (!presetn)
    compare_pad_output_enable_r |=> port_b_pin_3_oe && port_b_pin_3_out == $past(sync2_r))
    else $error("pin b3 not showing result");
  AST_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 sync2_r == $past(comparator_raw, 2))
    else $error("synchroniser depth wrong");
  AST_RESULT_READ: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == vcc_pkg::ADDR_STATUS |=> prdata[vcc_pkg::RESULT_BIT] == $past(sync2_r))
    else $error("result bit wrong");

  // Pad-to-pad pairs, reserved codes, a pad-to-reference pad and the quiet state when off
  AST_P2P_PAIR0: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == vcc_pkg::VCC_MODE_P2P && pad_pair_select == vcc_pkg::PAIR_0) |=>
    noninv_pad_sel == 4'h1 && inv_pad_sel == 4'h2)
    else $error("first pair wrong");
  AST_P2P_PAIR2: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == vcc_pkg::VCC_MODE_P2P && pad_pair_select == vcc_pkg::PAIR_2) |=>
    noninv_pad_sel == 4'h4 && inv_pad_sel == 4'h8)
    else $error("second pair wrong");
  AST_P2P_PAIR3: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == vcc_pkg::VCC_MODE_P2P && pad_pair_select == vcc_pkg::PAIR_3) |=>
    noninv_pad_sel == 4'h8 && inv_pad_sel == 4'h4)
    else $error("second pair swap wrong");
  AST_P2P_NONE: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == vcc_pkg::VCC_MODE_P2P && pad_pair_select[3:2] != 2'b00) |=>
    noninv_pad_sel == 4'h0 && inv_pad_sel == 4'h0)
    else $error("pads chosen for reserved pair code");
  AST_P2R_PAD: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == vcc_pkg::VCC_MODE_P2R && pad_pair_select == vcc_pkg::PAIR_3) |=> noninv_pad_sel == 4'h8)
    else $error("wrong pad on non-inverting input");
  AST_OFF_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == vcc_pkg::VCC_MODE_OFF) |=> ladder_tap_sel == 16'h0000 && noninv_pad_sel == 4'h0 && inv_pad_sel == 4'h0)
    else $error("selects active while comparator off");

  // Power, request gating, flag arming and bus answer
  AST_POWER_ON: assert property (@(posedge pclk) disable iff (!presetn)
    comparator_enable && !halt_mode |=> comparator_power_on)
    else $error("comparator not powered while enabled");
  AST_CIRQ_RAISE: assert property (@(posedge pclk) disable iff (!presetn)
    compare_irq_flag_r && comparator_enable && compare_irq_enable_r && global_irq_enable_r |=> compare_irq)
    else $error("request not raised");
  AST_CIRQ_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    !global_irq_enable_r |=> !compare_irq)
    else $error("request passed with global enable off");
  AST_NO_FLAG_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !cmp_active && !compare_irq_flag_r |=> !compare_irq_flag_r)
    else $error("flag set while comparator off");
  AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    compare_irq_flag_r && irq_mask_r |=> irq)
    else $error("unmasked flag gave no interrupt");
  AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready && pslverr == !$past(mapped))
    else $error("bus answer missing");

  COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(compare_irq));
  COV_P2P: cover property (@(posedge pclk) disable iff (!presetn) mode == vcc_pkg::VCC_MODE_P2P);
  COV_PAD: cover property (@(posedge pclk) disable iff (!presetn) $rose(port_b_pin_3_oe));
  COV_CLR: cover property (@(posedge pclk) disable iff (!presetn) $fell(compare_irq_flag_r));
  COV_HALT: cover property (@(posedge pclk) disable iff (!presetn) comparator_enable && halt_mode);

endmodule : vcc_top

// ==== tb/test_voltage_comparator_control.sv ====
// Self-checking bench for the voltage comparator control block, driven over APB.
// Assumes vcc_top answers every APB transfer with zero wait states and 8-bit registers in the low byte.
`timescale 1ns/1ps

module test_voltage_comparator_control;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic halt_mode = 1'b0;
  logic comparator_raw = 1'b0;
  logic pulse_in = 1'b0;
  logic pulse_en = 1'b0;
  logic comparator_power_on;
  logic [15:0] ladder_tap_sel;
  logic [3:0] noninv_pad_sel;
  logic [3:0] inv_pad_sel;
  logic port_b_pin_3_out;
  logic port_b_pin_3_oe;
  logic compare_irq;
  logic irq;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////
  // Clock, device and hang guard
  always #12.5 pclk = ~pclk;

  vcc_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_mode(halt_mode), .comparator_raw(comparator_raw),
    .pulse_width_output_one_in(pulse_in), .pulse_width_output_one_en(pulse_en),
    .comparator_power_on(comparator_power_on), .ladder_tap_sel(ladder_tap_sel),
    .noninv_pad_sel(noninv_pad_sel), .inv_pad_sel(inv_pad_sel),
    .port_b_pin_3_out(port_b_pin_3_out), .port_b_pin_3_oe(port_b_pin_3_oe),
    .compare_irq(compare_irq), .irq(irq)
  );

  // Whole run needs about 540 cycles; the ceiling leaves ample room
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // Request held until pready is sampled high; data taken at that edge only
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask : rdchk

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk("power", comparator_power_on, 32'h0);
    chk("cirq", compare_irq, 32'h0);
    rdchk("enable", 8'h00, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", err, 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask : t_reset

  task automatic t_enable();
    apb(1'b1, 8'h00, 32'h80);
    rdchk("enable", 8'h00, 32'h80);
    chk("power on", comparator_power_on, 32'h1);
    halt_mode <= 1'b1;
    tick(3);
    chk("power halt", comparator_power_on, 32'h0);
    halt_mode <= 1'b0;
    tick(3);
    chk("power back", comparator_power_on, 32'h1);
  endtask : t_enable

  // Every level code against pair codes 0 to 4, the valid ones and one code past them
  task automatic t_select();
    logic [15:0] el;
    logic [3:0] en;
    logic [3:0] ei;
    for (int lv = 0; lv < 16; lv++) begin
      for (int ps = 0; ps < 5; ps++) begin
        apb(1'b1, 8'h04, {24'h0, ps[3:0], lv[3:0]});
        tick(2);
        el = (lv == 0) ? 16'h0 : 16'h1 << lv;
        en = (ps < 4) ? 4'h1 << ps : 4'h0;
        ei = (lv == 0 && ps < 4) ? 4'h1 << (ps ^ 1) : 4'h0;
        chk("ladder", ladder_tap_sel, el);
        chk("noninv", noninv_pad_sel, en);
        chk("inv", inv_pad_sel, ei);
      end
    end
  endtask : t_select

  task automatic t_flag();
    apb(1'b1, 8'h0c, 32'h3);
    apb(1'b1, 8'h14, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    apb(1'b1, 8'h10, 32'h1);
    comparator_raw <= 1'b1;
    tick(6);
    chk("cirq set", compare_irq, 32'h1);
    chk("irq set", irq, 32'h1);
    rdchk("flag", 8'h10, 32'h1);
    rdchk("result", 8'h08, 32'h80);
    tick(20);
    rdchk("flag sticky", 8'h10, 32'h1);
    apb(1'b1, 8'h0c, 32'h5);
    tick(2);
    chk("cirq gie off", compare_irq, 32'h0);
    apb(1'b1, 8'h14, 32'h0);
    tick(2);
    chk("irq masked", irq, 32'h0);
    apb(1'b1, 8'h0c, 32'h3);
    rdchk("flag zero", 8'h10, 32'h0);
    // Result falls against the copy loaded by the status read, so the cleared flag sets again
    comparator_raw <= 1'b0;
    tick(6);
    chk("cirq again", compare_irq, 32'h1);
    apb(1'b1, 8'h00, 32'h0);
    tick(2);
    chk("cirq disabled", compare_irq, 32'h0);
    apb(1'b1, 8'h00, 32'h80);
    apb(1'b0, 8'h08, 32'h0);
    apb(1'b1, 8'h10, 32'h1);
    tick(6);
    rdchk("flag after reload", 8'h10, 32'h0);
  endtask : t_flag

  task automatic t_pad();
    pulse_in <= 1'b1;
    pulse_en <= 1'b1;
    tick(3);
    chk("pin pulse", port_b_pin_3_out, 32'h1);
    chk("pin pulse oe", port_b_pin_3_oe, 32'h1);
    apb(1'b1, 8'h08, 32'h40);
    tick(3);
    chk("pin low", port_b_pin_3_out, 32'h0);
    // Pulse enable dropped so the pin enable can only come from the override
    pulse_en <= 1'b0;
    tick(3);
    chk("pin oe", port_b_pin_3_oe, 32'h1);
    comparator_raw <= 1'b1;
    pulse_in <= 1'b0;
    tick(4);
    chk("pin high", port_b_pin_3_out, 32'h1);
    rdchk("status", 8'h08, 32'hc0);
    apb(1'b1, 8'h08, 32'h0);
    tick(3);
    chk("pin released", port_b_pin_3_oe, 32'h0);
  endtask : t_pad

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    tick(4);
    presetn <= 1'b1;
    t_reset();
    t_enable();
    t_select();
    t_flag();
    t_pad();
    complete_run();
  end
endmodule : test_voltage_comparator_control
